/* core/mid_defs.vh */
// Constants for the instruction decoder: widths, field positions, opcodes.
// Assumes inclusion by the decoder and by its bench, by bare name.
`ifndef MID_DEFS_VH
`define MID_DEFS_VH
`define MID_IW            14
`define MID_CAT_HI        13
`define MID_CAT_LO        12
`define MID_CAT_BYTE      2'h0
`define MID_CAT_BIT       2'h1
`define MID_CAT_JUMP      2'h2
`define MID_CAT_LIT       2'h3
`define MID_FADDR_HI      6
`define MID_DEST_POS      7
`define MID_BIT_HI        9
`define MID_BIT_LO        7
`define MID_OP4_HI        11
`define MID_OP4_LO        8
`define MID_K11_HI        10
`define MID_CALL_POS      11
`define MID_Q_PER_CYCLE   2'h3
// Byte-oriented opcodes, bits 11..8
`define MID_OP_MISC       4'h0
`define MID_OP_CLR        4'h1
`define MID_OP_SUB        4'h2
`define MID_OP_DEC        4'h3
`define MID_OP_IOR        4'h4
`define MID_OP_AND        4'h5
`define MID_OP_XOR        4'h6
`define MID_OP_ADD        4'h7
`define MID_OP_MOV        4'h8
`define MID_OP_COM        4'h9
`define MID_OP_INC        4'hA
`define MID_OP_DECSZ      4'hB
`define MID_OP_RRF        4'hC
`define MID_OP_RLF        4'hD
`define MID_OP_SWAP       4'hE
`define MID_OP_INCSZ      4'hF
// Misc low bytes
`define MID_LO_RETURN     8'h08
`define MID_LO_RETFIE     8'h09
`define MID_LO_SLEEP      8'h63
`define MID_LO_CLRWDT     8'h64
`define MID_LO_OPTION     8'h62
`define MID_LO_LEGACY_TRISTATE_LOAD_HI    5'h0C
// Literal group opcodes, bits 11..8
`define MID_LIT_IOR       4'h8
`define MID_LIT_AND       4'h9
`define MID_LIT_XOR       4'hA
`define MID_ALU_W         4'h0
`define MID_ALU_BCF       4'h1
`define MID_ALU_BSF       4'h2
`define MID_ALU_BTFSC     4'h3
`define MID_ALU_BTFSS     4'h4
`define MID_ALU_MOVLW     4'h5
`define MID_ALU_RETLW     4'h6
`define MID_ALU_IORLW     4'h7
`define MID_ALU_ANDLW     4'h8
`define MID_ALU_XORLW     4'h9
`define MID_ALU_SUBLW     4'hA
`define MID_ALU_ADDLW     4'hB
`define MID_ALU_NONE      4'hF
`endif

/* core/mid_decoder.v */
// Instruction decoder: splits 14-bit words into fields and classes and
// paces execution in four-period instruction cycles with a flush cycle.
// Assumes program memory presents the next word, sampled at the Q4 edge,
// and that the datapath reports skip tests through skip_true_in.
// Reset leaves a NOP in the instruction register, so no flag is raised.
//
// Operation
// RL1 - Every instruction is taken as one 14-bit word of opcode plus operand fields in three groups.
// RL2 - Byte operations write the accumulator when the destination bit is 0, else the file register.
// RL3 - The file address field is seven bits wide and selects registers 0x00 to 0x7F.
// RL4 - Bit operations take a three-bit number selecting one bit of the addressed 8-bit register.
// RL5 - Literal and control operations yield an 8-bit or an 11-bit constant as the instruction needs.
// RL6 - Don't-care opcode bits never change how an instruction decodes.
// RL7 - One cycle per instruction, two when a test is true or the PC changes, the second a no-op.
// RL8 - Each instruction cycle is four consecutive oscillator periods.
// RL9 - Software should avoid the legacy option-load and tristate-load instructions.
// RL10 - The two top opcode bits pick the category before the rest is interpreted.
`timescale 1ns/1ps
`include "mid_defs.vh"
module mid_decoder #(
   parameter IW = `MID_IW
) (
   input  wire          mclk_in,
   input  wire          arst_n_in,
   input  wire [IW-1:0] instr_in,
   input  wire          skip_true_in,
   output wire          q_end_out,
   output reg  [1:0]    q_phase_out,
   output reg  [1:0]    category_out,
   output reg  [3:0]    byte_op_out,
   output reg  [3:0]    alu_op_out,
   output reg  [6:0]    file_addr_out,
   output reg  [2:0]    bit_num_out,
   output reg  [7:0]    bit_mask_out,
   output reg  [7:0]    lit8_out,
   output reg  [10:0]   lit11_out,
   output reg           dest_file_out,
   output reg           write_w_out,
   output reg           write_f_out,
   output reg           is_call_out,
   output reg           is_goto_out,
   output reg           is_return_out,
   output reg           is_retfie_out,
   output reg           is_sleep_out,
   output reg           is_clrwdt_out,
   output reg           legacy_tristate_load_out,
   output reg           legacy_option_load_out,
   output reg           is_skip_test_out,
   output reg           flush_out
);
   reg  [1:0]  q_reg;
   reg  [IW-1:0] ir_reg;
   reg         flush_reg;
   reg         flush_next;
   wire [1:0]  cat;
   wire [3:0]  op4;
   wire [7:0]  lo8;
   reg         pc_change;
   reg         skip_type;

   assign cat = ir_reg[`MID_CAT_HI:`MID_CAT_LO];
   assign op4 = ir_reg[`MID_OP4_HI:`MID_OP4_LO];
   assign lo8 = ir_reg[7:0];
   // Combinational so memory sees the fetch slot in the same period
   assign q_end_out = (q_reg == `MID_Q_PER_CYCLE);

   function [7:0] onehot8;
      input [2:0] n;
      begin
         onehot8 = 8'h01 << n;
      end
   endfunction

   // Instruction cycle = four oscillator periods
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         q_reg     <= 2'h0;
         ir_reg    <= {IW{1'b0}};
         flush_reg <= 1'b0;
      end else begin
         q_reg <= q_reg + 2'h1; // RL8
         // Word taken in the last period; memory has three periods to settle
         if (q_end_out) begin
            ir_reg    <= instr_in; // RL1
            flush_reg <= flush_next; // RL7
         end
      end
   end

   // Taken skip or PC change flushes the prefetched word
   always @* begin
      // A flushed word never flushes the next, so flushes cannot chain
      flush_next = !flush_reg && (pc_change || (skip_type && skip_true_in)); // RL7
   end

   always @* begin
      q_phase_out   = q_reg;
      flush_out     = flush_reg;
      category_out  = cat; // RL10
      byte_op_out   = op4;
      file_addr_out = ir_reg[`MID_FADDR_HI:0]; // RL3
      bit_num_out   = ir_reg[`MID_BIT_HI:`MID_BIT_LO]; // RL4
      bit_mask_out  = onehot8(ir_reg[`MID_BIT_HI:`MID_BIT_LO]); // RL4
      lit8_out      = lo8; // RL5
      lit11_out     = ir_reg[`MID_K11_HI:0]; // RL5
      dest_file_out = ir_reg[`MID_DEST_POS]; // RL2
      alu_op_out    = `MID_ALU_NONE;
      write_w_out   = 1'b0;
      write_f_out   = 1'b0;
      is_call_out   = 1'b0;
      is_goto_out   = 1'b0;
      is_return_out = 1'b0;
      is_retfie_out = 1'b0;
      is_sleep_out  = 1'b0;
      is_clrwdt_out = 1'b0;
      legacy_tristate_load_out = 1'b0;
      legacy_option_load_out   = 1'b0;
      pc_change     = 1'b0;
      skip_type     = 1'b0;
      case (cat) // RL10
         `MID_CAT_BYTE: begin
            alu_op_out = `MID_ALU_W;
            if (op4 == `MID_OP_MISC) begin
               if (ir_reg[`MID_DEST_POS]) begin
                  write_f_out = 1'b1; // Store accumulator to file
               end else if (lo8 == `MID_LO_RETURN) begin
                  is_return_out = 1'b1;
                  pc_change     = 1'b1; // RL7
               end else if (lo8 == `MID_LO_RETFIE) begin
                  is_retfie_out = 1'b1;
                  pc_change     = 1'b1; // RL7
               end else if (lo8 == `MID_LO_SLEEP) begin
                  is_sleep_out = 1'b1;
               end else if (lo8 == `MID_LO_CLRWDT) begin
                  is_clrwdt_out = 1'b1;
               end else if (lo8 == `MID_LO_OPTION) begin
                  legacy_option_load_out = 1'b1; // RL9
               end else if ((lo8[7:3] == `MID_LO_LEGACY_TRISTATE_LOAD_HI) && (lo8[2:0] != 3'h0)) begin // RL6
                  // Register 0 form is also a NOP pattern; the NOP wins
                  legacy_tristate_load_out = 1'b1; // RL9
               end
               // Remaining forms, including all no-op variants, do nothing
            end else if (op4 == `MID_OP_CLR) begin
               // Clear of W ignores its seven don't-care bits
               write_f_out = ir_reg[`MID_DEST_POS]; // RL6
               write_w_out = !ir_reg[`MID_DEST_POS]; // RL6
            end else begin
               write_f_out = ir_reg[`MID_DEST_POS]; // RL2
               write_w_out = !ir_reg[`MID_DEST_POS]; // RL2
               // Zero test is the datapath's; only the skip class is flagged here
               skip_type   = (op4 == `MID_OP_DECSZ) || (op4 == `MID_OP_INCSZ); // RL7
            end
         end
         `MID_CAT_BIT: begin
            case (ir_reg[`MID_OP4_HI:`MID_OP4_HI-1])
               2'h0: begin
                  alu_op_out  = `MID_ALU_BCF;
                  write_f_out = 1'b1; // RL4
               end
               2'h1: begin
                  alu_op_out  = `MID_ALU_BSF;
                  write_f_out = 1'b1; // RL4
               end
               2'h2: begin
                  alu_op_out = `MID_ALU_BTFSC;
                  skip_type  = 1'b1; // RL7
               end
               default: begin
                  alu_op_out = `MID_ALU_BTFSS;
                  skip_type  = 1'b1; // RL7
               end
            endcase
         end
         `MID_CAT_JUMP: begin
            is_call_out = !ir_reg[`MID_CALL_POS];
            is_goto_out = ir_reg[`MID_CALL_POS];
            pc_change   = 1'b1; // RL7
         end
         default: begin
            write_w_out = 1'b1;
            // Only decisive bits are compared; x positions masked
            if (op4[3:2] == 2'h0) begin
               alu_op_out = `MID_ALU_MOVLW; // RL6
            end else if (op4[3:2] == 2'h1) begin
               alu_op_out = `MID_ALU_RETLW; // RL6
               pc_change  = 1'b1; // RL7
            end else if (op4 == `MID_LIT_IOR) begin
               alu_op_out = `MID_ALU_IORLW;
            end else if (op4 == `MID_LIT_AND) begin
               alu_op_out = `MID_ALU_ANDLW;
            end else if (op4 == `MID_LIT_XOR) begin
               alu_op_out = `MID_ALU_XORLW;
            end else if (op4[3:1] == 3'h6) begin
               alu_op_out = `MID_ALU_SUBLW; // RL6
            end else if (op4[3:1] == 3'h7) begin
               alu_op_out = `MID_ALU_ADDLW; // RL6
            end else begin
               // Pattern 1011 is unassigned and acts as a no-op
               alu_op_out  = `MID_ALU_NONE;
               write_w_out = 1'b0;
            end
         end
      endcase
      // Flush cycle executes as a no-op
      if (flush_reg) begin // RL7
         alu_op_out    = `MID_ALU_NONE;
         write_w_out   = 1'b0;
         write_f_out   = 1'b0;
         is_call_out   = 1'b0;
         is_goto_out   = 1'b0;
         is_return_out = 1'b0;
         is_retfie_out = 1'b0;
         is_sleep_out  = 1'b0;
         is_clrwdt_out = 1'b0;
         legacy_tristate_load_out = 1'b0;
         legacy_option_load_out   = 1'b0;
         pc_change     = 1'b0;
         skip_type     = 1'b0;
      end
      is_skip_test_out = skip_type;
   end
endmodule // mid_decoder

/* testbench/mid_prog_mem.sv */
// Program memory model: offers the bench's chosen word to the decoder.
// Assumes the decoder samples the word only while q_end is high.
`timescale 1ns/1ps
module mid_prog_mem (
   input  wire        q_end_in,
   input  wire [13:0] word_in,
   output wire [13:0] instr_out
);
   // Inverted outside the fetch slot, so a mistimed sample shows up
   // Legacy loads come only from the scenario that checks they are flagged
   assign instr_out = q_end_in ? word_in : ~word_in;
endmodule // mid_prog_mem

/* testbench/mid_decoder_sva.sv */
// Checker: cycle timing and field relations of the instruction decoder.
// Assumes it is bound to mid_decoder and sees its ports only.
`timescale 1ns/1ps
module mid_decoder_sva #(
   parameter IW = 14
) (
   input wire          mclk_in,
   input wire          arst_n_in,
   input wire [IW-1:0] instr_in,
   input wire          skip_true_in,
   input wire          q_end_out,
   input wire [1:0]    q_phase_out,
   input wire [1:0]    category_out,
   input wire [3:0]    byte_op_out,
   input wire [6:0]    file_addr_out,
   input wire [2:0]    bit_num_out,
   input wire [7:0]    bit_mask_out,
   input wire [10:0]   lit11_out,
   input wire          dest_file_out,
   input wire          write_w_out,
   input wire          write_f_out,
   input wire          is_goto_out,
   input wire          is_skip_test_out,
   input wire          flush_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   a_qend_phase: assert property (q_end_out == (q_phase_out == 2'h3))
      else $error("q_end not in last period");
   a_cycle_four: assert property (q_end_out |=> q_phase_out == 2'h0 ##1 q_phase_out == 2'h1
      ##1 q_phase_out == 2'h2 ##1 q_phase_out == 2'h3) else $error("cycle not four periods");
   a_cat_field: assert property (q_end_out |=> category_out == $past(instr_in[13:12]))
      else $error("category not from top bits");
   a_addr_lit: assert property (q_end_out |=> file_addr_out == $past(instr_in[6:0])
      && lit11_out == $past(instr_in[10:0])) else $error("address or literal field wrong");
   a_bit_mask: assert property (bit_mask_out == (8'h01 << bit_num_out))
      else $error("bit mask wrong");
   a_dest_route: assert property ((category_out == 2'h0 && byte_op_out != 4'h0 && !flush_out)
      |-> write_f_out == dest_file_out && write_w_out == !dest_file_out) else $error("bad dest");
   a_goto_flush: assert property (q_end_out && is_goto_out && !flush_out |=> flush_out)
      else $error("no flush after goto");
   a_skip_flush: assert property (q_end_out && is_skip_test_out && skip_true_in && !flush_out
      |=> flush_out) else $error("no flush after true skip");
   a_flush_len: assert property ($rose(flush_out) |-> flush_out[*4] ##1 !flush_out)
      else $error("flush not one cycle");
   a_flush_quiet: assert property (flush_out |-> !(is_goto_out || write_w_out || write_f_out))
      else $error("action during flush");
endmodule // mid_decoder_sva
bind mid_decoder mid_decoder_sva #(.IW(IW)) u_sva (
   .mclk_in(mclk_in), .arst_n_in(arst_n_in), .instr_in(instr_in), .skip_true_in(skip_true_in),
   .q_end_out(q_end_out), .q_phase_out(q_phase_out), .category_out(category_out),
   .byte_op_out(byte_op_out), .file_addr_out(file_addr_out), .bit_num_out(bit_num_out),
   .bit_mask_out(bit_mask_out), .lit11_out(lit11_out), .dest_file_out(dest_file_out),
   .write_w_out(write_w_out), .write_f_out(write_f_out), .is_goto_out(is_goto_out),
   .is_skip_test_out(is_skip_test_out), .flush_out(flush_out));

/* testbench/testbench.sv */
// Testbench: feeds words through the memory model and checks the decode.
// Assumes core/ is on the include path for mid_defs.vh.
`timescale 1ns/1ps
`include "mid_defs.vh"
module testbench;
   logic        mclk_in = 1'h0;
   logic        arst_n_in = 1'h0;
   logic        skip_true_in = 1'h0;
   logic [13:0] word = 14'h0000;
   wire  [13:0] instr_in;
   wire         q_end_out, write_w_out, write_f_out, is_call_out, is_goto_out;
   wire         is_skip_test_out, flush_out;
   wire         is_return_out, is_retfie_out, is_sleep_out, is_clrwdt_out;
   wire         legacy_tristate_load_out, legacy_option_load_out;
   wire  [1:0]  category_out;
   wire  [3:0]  byte_op_out, alu_op_out;
   wire  [6:0]  file_addr_out;
   wire  [2:0]  bit_num_out;
   wire  [7:0]  bit_mask_out, lit8_out;
   wire  [10:0] lit11_out;
   integer      errors = 0;
   integer      num_checks = 0;
   integer      cycles = 0;
   always #12.5 mclk_in = ~mclk_in;
   mid_prog_mem PM (.q_end_in(q_end_out), .word_in(word), .instr_out(instr_in));
   mid_decoder DUT (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .instr_in(instr_in),
      .skip_true_in(skip_true_in), .q_end_out(q_end_out), .q_phase_out(),
      .category_out(category_out), .byte_op_out(byte_op_out), .alu_op_out(alu_op_out),
      .file_addr_out(file_addr_out), .bit_num_out(bit_num_out), .bit_mask_out(bit_mask_out),
      .lit8_out(lit8_out), .lit11_out(lit11_out), .dest_file_out(), .write_w_out(write_w_out),
      .write_f_out(write_f_out), .is_call_out(is_call_out), .is_goto_out(is_goto_out),
      .is_return_out(is_return_out), .is_retfie_out(is_retfie_out),
      .is_sleep_out(is_sleep_out), .is_clrwdt_out(is_clrwdt_out),
      .legacy_tristate_load_out(legacy_tristate_load_out),
      .legacy_option_load_out(legacy_option_load_out),
      .is_skip_test_out(is_skip_test_out), .flush_out(flush_out));
   task wrap_up;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input [15:0] seen, input [15:0] exp, input string nm);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Waits for the fetch slot, offers the word, returns 1 ns into its cycle
   task issue(input [13:0] w, input s);
      integer n;
      n = 0;
      while (q_end_out !== 1'h1 && n < 8) begin
         @(posedge mclk_in);
         #1;
         n = n + 1;
      end
      word = w;
      skip_true_in = s;
      @(posedge mclk_in);
      #1;
   endtask
   task t_byte;
      integer op, d;
      for (op = 1; op < 16; op = op + 1) begin
         for (d = 0; d < 2; d = d + 1) begin
            issue({2'h0, op[3:0], d[0], (op[0] ? 7'h7F : 7'h00)}, 1'h0);
            chk(category_out, 2'h0, "category");
            chk(byte_op_out, op[3:0], "byte_op");
            chk(file_addr_out, op[0] ? 7'h7F : 7'h00, "file_addr");
            chk(write_f_out, d[0], "write_f");
            chk(write_w_out, !d[0], "write_w");
         end
      end
   endtask
   task t_bit;
      integer b;
      for (b = 0; b < 8; b = b + 1) begin
         issue({4'h5, b[2:0], 7'h55}, 1'h0);
         chk(category_out, 2'h1, "category");
         chk(bit_num_out, b[2:0], "bit_num");
         chk(bit_mask_out, 8'h01 << b[2:0], "bit_mask");
         chk(file_addr_out, 7'h55, "file_addr");
      end
   endtask
   task t_lit;
      integer x;
      for (x = 0; x < 4; x = x + 1) begin
         issue({4'hC, x[1:0], 8'hA5}, 1'h0);
         chk(alu_op_out, `MID_ALU_MOVLW, "movlw");
         chk(lit8_out, 8'hA5, "lit8");
         issue({5'h1F, x[0], 8'h3C}, 1'h0);
         chk(alu_op_out, `MID_ALU_ADDLW, "addlw");
      end
   endtask
   task t_jump;
      issue(14'h2FA5, 1'h0);
      chk(is_goto_out, 1'h1, "goto");
      chk(lit11_out, 11'h7A5, "lit11");
      issue(14'h2123, 1'h0);
      chk(flush_out, 1'h1, "flush");
      chk(is_call_out, 1'h0, "call_dropped");
      issue(14'h2123, 1'h0);
      chk(is_call_out, 1'h1, "call");
      issue(14'h0000, 1'h0);
      chk(flush_out, 1'h1, "flush");
   endtask
   task t_skip;
      issue(14'h1803, 1'h0);
      chk(is_skip_test_out, 1'h1, "skip_test");
      issue(14'h30A5, 1'h1);
      chk(flush_out, 1'h1, "flush");
      chk(write_w_out, 1'h0, "write_w");
      issue(14'h1C03, 1'h0);
      issue(14'h30A5, 1'h0);
      chk(flush_out, 1'h0, "flush");
      chk(write_w_out, 1'h1, "write_w");
   endtask
   task t_misc;
      issue(14'h0063, 1'h0);
      chk(is_sleep_out, 1'h1, "sleep");
      issue(14'h0064, 1'h0);
      chk(is_clrwdt_out, 1'h1, "clrwdt");
      issue(14'h0062, 1'h0);
      chk(legacy_option_load_out, 1'h1, "option_load");
      issue(14'h0066, 1'h0);
      chk(legacy_tristate_load_out, 1'h1, "tristate_load");
      issue(14'h0060, 1'h0);
      chk(legacy_tristate_load_out, 1'h0, "nop_form");
      chk(write_w_out | write_f_out, 1'h0, "nop_quiet");
      issue(14'h00A5, 1'h0);
      chk(write_f_out, 1'h1, "movwf");
      chk(file_addr_out, 7'h25, "movwf_addr");
      issue(14'h0009, 1'h0);
      chk(is_retfie_out, 1'h1, "retfie");
      issue(14'h0008, 1'h0);
      chk(is_return_out, 1'h0, "return_dropped");
      issue(14'h0008, 1'h0);
      chk(is_return_out, 1'h1, "return");
      issue(14'h3455, 1'h0);
      chk(flush_out, 1'h1, "flush");
      issue(14'h3755, 1'h0);
      chk(alu_op_out, `MID_ALU_RETLW, "retlw");
      chk(lit8_out, 8'h55, "retlw_lit");
      issue(14'h3800, 1'h0);
      chk(write_w_out, 1'h0, "write_w");
      issue(14'h3800, 1'h0);
      chk(alu_op_out, `MID_ALU_IORLW, "iorlw");
      issue(14'h3900, 1'h0);
      chk(alu_op_out, `MID_ALU_ANDLW, "andlw");
      issue(14'h3A00, 1'h0);
      chk(alu_op_out, `MID_ALU_XORLW, "xorlw");
      issue(14'h3D00, 1'h0);
      chk(alu_op_out, `MID_ALU_SUBLW, "sublw");
      issue(14'h3B00, 1'h0);
      chk(write_w_out, 1'h0, "unassigned");
      issue(14'h0B80, 1'h0);
      chk(is_skip_test_out, 1'h1, "skip_test");
      issue(14'h3800, 1'h1);
      chk(flush_out, 1'h1, "flush");
   endtask
   always @(posedge mclk_in) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         errors = errors + 1;
         wrap_up;
      end
   end
   initial begin
      repeat (6) @(posedge mclk_in);
      #1 arst_n_in = 1'h1;
      t_byte;
      t_bit;
      t_lit;
      t_jump;
      t_skip;
      t_misc;
      wrap_up;
   end
endmodule // testbench
